// >>> include/acsd_pkg.sv
package acsd_pkg;

  // ****************************************************************
  // Address field positions
  // ****************************************************************
  localparam int AREA_LSB         = 24;  // Area number low bit
  localparam int AREA_MSB         = 26;  // Area number high bit
  localparam int WIDTH_SEL_BIT    = 27;  // Primary width switch
  localparam int PERIPH_WIDTH_BIT = 8;   // Peripheral 8/16 switch
  localparam int MIO_WIDTH_BIT    = 14;  // Area 6 8/16 switch
  localparam int DRAM_ROW_SHIFT   = 8;   // Row address shift

  // ****************************************************************
  // Alias masks on the 24-bit in-area offset
  // ****************************************************************
  localparam logic [23:0] ROM16K_MASK = 24'h003FFF;
  localparam logic [23:0] ROM32K_MASK = 24'h007FFF;
  localparam logic [23:0] PERIPH_MASK = 24'h0001FF;
  localparam logic [23:0] RAM_MASK    = 24'h0003FF;
  localparam logic [23:0] EXT_MASK    = 24'h3FFFFF;

  // ****************************************************************
  // Areas, mode pin codes, idle values
  // ****************************************************************
  localparam logic [2:0] AREA_BOOT   = 3'h0;
  localparam logic [2:0] AREA_DRAM   = 3'h1;
  localparam logic [2:0] AREA_EXT2   = 3'h2;
  localparam logic [2:0] AREA_EXT3   = 3'h3;
  localparam logic [2:0] AREA_EXT4   = 3'h4;
  localparam logic [2:0] AREA_PERIPH = 3'h5;
  localparam logic [2:0] AREA_MIO    = 3'h6;
  localparam logic [2:0] AREA_RAM    = 3'h7;
  localparam logic [2:0] MODE_EXT8   = 3'h0;
  localparam logic [2:0] MODE_EXT16  = 3'h1;
  localparam logic [2:0] MODE_ROM    = 3'h2;
  localparam logic [7:0] CS_IDLE     = 8'hFF;  // All selects released
  localparam logic [1:0] OE_OFF      = 2'h3;   // Both lanes released

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SP_EXT, SP_DRAM, SP_MIO, SP_ROM, SP_PERIPH, SP_RAM
  } acsd_space_t;
  typedef enum logic [1:0] {BW_8, BW_16, BW_32} acsd_width_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} acsd_size_t;

endpackage

// >>> hw/acsd_decoder.sv
`timescale 1ns/1ps
module acsd_decoder (
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [31:0]          req_addr,
  input  wire acsd_pkg::acsd_size_t req_size,
  input  wire logic                 req_write,
  input  wire logic [31:0]          req_wdata,
  input  wire logic [2:0]           boot_mode_pins,
  input  wire logic                 rom_is_32k,
  input  wire logic                 dram_space_enable,
  input  wire logic                 row_col_multiplex_enable,
  input  wire logic                 muxed_io_enable,
  input  wire logic                 low_areas_long_wait_hi,
  input  wire logic                 low_areas_long_wait_lo,
  input  wire logic                 area_six_long_wait_hi,
  input  wire logic                 area_six_long_wait_lo,
  output logic [7:0]                area_select_n,
  output logic                      ext_cycle,
  output acsd_pkg::acsd_space_t     space,
  output acsd_pkg::acsd_width_t     bus_width,
  output logic [23:0]               ext_addr,
  output logic [15:0]               shared_addr_data_pins_out,
  output logic [1:0]                shared_addr_data_pins_oe_n,
  output logic                      addr_phase,
  output logic                      beat_end,
  output logic                      xfer_done
);
  import acsd_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} acsd_state_t;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] mode_meta_r;   // First stage, read only by second
  logic [2:0] mode_sync_r;   // Mode pins, safe to decode
  logic       rom32_meta_r;  // First stage of ROM size strap
  logic       rom32_sync_r;  // ROM size strap, safe to use

  // Straps may move at any time; two stages tame metastability
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_meta_r  <= MODE_EXT8;
      mode_sync_r  <= MODE_EXT8;
      rom32_meta_r <= 1'b0;
      rom32_sync_r <= 1'b0;
    end else if (clk_en) begin
      mode_meta_r  <= boot_mode_pins;
      mode_sync_r  <= mode_meta_r;
      rom32_meta_r <= rom_is_32k;
      rom32_sync_r <= rom32_meta_r;
    end
  end

  // ****************************************************************
  // Address decode of the incoming request
  // ****************************************************************
  logic [2:0]  dec_area;     // Area number
  logic        dec_a27;      // Primary width bit
  acsd_space_t dec_space;    // Kind of space reached
  acsd_width_t dec_width;    // Bus width of that space
  logic [2:0]  dec_lw;       // Long waits, zero when none
  logic [1:0]  dec_beats_m1; // Bus beats minus one
  logic        dec_need_addr;// Separate address phase wanted
  logic [2:0]  lw_low_cfg;   // Areas 0/2 long waits, 1..4
  logic [2:0]  lw_six_cfg;   // Area 6 long waits, 1..4

  assign lw_low_cfg = {1'b0, low_areas_long_wait_hi,
                       low_areas_long_wait_lo} + 3'h1;
  assign lw_six_cfg = {1'b0, area_six_long_wait_hi,
                       area_six_long_wait_lo} + 3'h1;

  // Bits 31..28 never enter the decode
  always_comb begin
    dec_area  = req_addr[AREA_MSB:AREA_LSB];
    dec_a27   = req_addr[WIDTH_SEL_BIT];
    dec_space = SP_EXT;
    dec_width = dec_a27 ? BW_16 : BW_8;
    dec_lw    = 3'h0;
    case (dec_area)
      AREA_BOOT: begin
        // Mode pins win over bit 27 here
        case (mode_sync_r)
          MODE_ROM: begin
            dec_space = SP_ROM;
            dec_width = BW_32;
          end
          MODE_EXT16: dec_width = BW_16;
          default:    dec_width = BW_8;
        endcase
        if (dec_space == SP_EXT) begin
          dec_lw = lw_low_cfg;
        end
      end
      AREA_DRAM: begin
        if (dram_space_enable) begin
          dec_space = SP_DRAM;
        end
      end
      AREA_EXT2: dec_lw = lw_low_cfg;
      AREA_PERIPH: begin
        if (!dec_a27) begin
          dec_space = SP_PERIPH;
          dec_width = req_addr[PERIPH_WIDTH_BIT] ? BW_16 : BW_8;
        end
      end
      AREA_MIO: begin
        // Bit 14 picks the width only in the low half
        if (!dec_a27) begin
          dec_width = req_addr[MIO_WIDTH_BIT] ? BW_16 : BW_8;
          if (muxed_io_enable) begin
            dec_space = SP_MIO;
          end
        end
        if (dec_space == SP_EXT) begin
          dec_lw = lw_six_cfg;
        end
      end
      AREA_RAM: begin
        if (dec_a27) begin
          dec_space = SP_RAM;
          dec_width = BW_32;
        end else begin
          dec_width = BW_8;
        end
      end
      default: ;  // Areas 3 and 4: plain external
    endcase
    // Beats per access follow size over width
    dec_beats_m1 = 2'h0;
    case (req_size)
      SZ_WORD: dec_beats_m1 = (dec_width == BW_8) ? 2'h1 : 2'h0;
      SZ_LONG: begin
        case (dec_width)
          BW_8:    dec_beats_m1 = 2'h3;
          BW_16:   dec_beats_m1 = 2'h1;
          default: dec_beats_m1 = 2'h0;
        endcase
      end
      default: dec_beats_m1 = 2'h0;
    endcase
    dec_need_addr = (dec_space == SP_MIO) ||
                    (dec_space == SP_DRAM && row_col_multiplex_enable);
  end

  // ****************************************************************
  // Beat sequencer
  // ****************************************************************
  acsd_state_t st_r, st_nxt;           // Sequencer state
  logic [27:0] addr_r, addr_nxt;       // Request address
  logic [31:0] wdata_r, wdata_nxt;     // Write data
  logic        write_r, write_nxt;     // Write request
  acsd_space_t space_r, space_nxt;     // Space of current access
  acsd_width_t width_r, width_nxt;     // Width of current access
  logic [2:0]  lw_r, lw_nxt;           // Long waits per beat
  logic [2:0]  wait_r, wait_nxt;       // Long waits left in beat
  logic [1:0]  beats_r, beats_nxt;     // Last beat index
  logic [1:0]  beat_r, beat_nxt;       // Current beat index
  logic        need_addr_r, need_addr_nxt; // Address phase per beat
  logic        mux_r, mux_nxt;         // DRAM row/column in use

  assign req_ready = (st_r == ST_IDLE);
  assign beat_end  = (st_r == ST_DATA) && (wait_r == 3'h0);
  assign xfer_done = beat_end && (beat_r == beats_r);

  // Next-state logic; long waits stretch every data phase
  always_comb begin
    st_nxt = st_r;  addr_nxt = addr_r;  wdata_nxt = wdata_r;
    write_nxt = write_r;  space_nxt = space_r;  width_nxt = width_r;
    lw_nxt = lw_r;  wait_nxt = wait_r;  beats_nxt = beats_r;
    beat_nxt = beat_r;  need_addr_nxt = need_addr_r;  mux_nxt = mux_r;
    case (st_r)
      ST_IDLE: begin
        if (req_valid) begin
          addr_nxt      = req_addr[27:0];
          wdata_nxt     = req_wdata;
          write_nxt     = req_write;
          space_nxt     = dec_space;
          width_nxt     = dec_width;
          lw_nxt        = dec_lw;
          wait_nxt      = dec_lw;
          beats_nxt     = dec_beats_m1;
          beat_nxt      = 2'h0;
          need_addr_nxt = dec_need_addr;
          mux_nxt       = row_col_multiplex_enable;
          st_nxt        = dec_need_addr ? ST_ADDR : ST_DATA;
        end
      end
      ST_ADDR: st_nxt = ST_DATA;
      ST_DATA: begin
        if (wait_r != 3'h0) begin
          wait_nxt = wait_r - 3'h1;
        end else if (beat_r == beats_r) begin
          st_nxt = ST_IDLE;
        end else begin
          beat_nxt = beat_r + 2'h1;
          wait_nxt = lw_r;
          st_nxt   = need_addr_r ? ST_ADDR : ST_DATA;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // Pin values for the coming cycle
  // ****************************************************************
  logic [7:0]  cs_nxt;      // Chip selects
  logic [23:0] eaddr_nxt;   // Address pins
  logic [15:0] ad_nxt;      // Shared pin value
  logic [1:0]  oe_nxt;      // Shared pin enables, low drives
  logic        ext_nxt;     // External cycle flag
  logic [2:0]  boff;        // Byte offset of the beat
  logic [23:0] baddr;       // In-area beat address
  logic [4:0]  shamt;       // Write data lane shift
  logic [15:0] wlane;       // Write data of the beat

  always_comb begin
    boff  = (width_nxt == BW_8)  ? {1'b0, beat_nxt} :
            (width_nxt == BW_16) ? {beat_nxt, 1'b0} : 3'h0;
    baddr = addr_nxt[23:0] + {21'h0, boff};
    shamt = (width_nxt == BW_8) ? {beat_nxt, 3'h0}
                                : {beat_nxt[0], 4'h0};
    wlane = 16'(wdata_nxt >> shamt);
    // Bit 27 never reaches the pins: it picks only width and space
    case (space_nxt)
      SP_ROM:    eaddr_nxt = baddr & (rom32_sync_r ? ROM32K_MASK
                                                   : ROM16K_MASK);
      SP_PERIPH: eaddr_nxt = baddr & PERIPH_MASK;
      SP_RAM:    eaddr_nxt = baddr & RAM_MASK;
      SP_DRAM: begin
        // Row first, then column, on the low sixteen pins
        if (!mux_nxt) begin
          eaddr_nxt = baddr & EXT_MASK;
        end else if (st_nxt == ST_ADDR) begin
          eaddr_nxt = {8'h00, 16'(baddr >> DRAM_ROW_SHIFT)};
        end else begin
          eaddr_nxt = {8'h00, baddr[15:0]};
        end
      end
      default:   eaddr_nxt = baddr & EXT_MASK;
    endcase
    ext_nxt = (st_nxt != ST_IDLE) && (space_nxt == SP_EXT ||
              space_nxt == SP_MIO || space_nxt == SP_DRAM);
    // DRAM and on-chip spaces keep every select high
    cs_nxt = CS_IDLE;
    if (st_nxt != ST_IDLE &&
        (space_nxt == SP_EXT || space_nxt == SP_MIO)) begin
      cs_nxt = ~(8'h01 << addr_nxt[AREA_MSB:AREA_LSB]);
    end
    ad_nxt = 16'h0000;
    oe_nxt = OE_OFF;
    if (st_nxt == ST_ADDR && space_nxt == SP_MIO) begin
      ad_nxt = baddr[15:0];
      oe_nxt = (width_nxt == BW_16) ? 2'h0 : 2'h2;
    end else if (st_nxt == ST_DATA && ext_nxt && write_nxt) begin
      if (width_nxt == BW_8) begin
        ad_nxt = {8'h00, wlane[7:0]};
        oe_nxt = 2'h2;
      end else begin
        ad_nxt = wlane;
        oe_nxt = 2'h0;
      end
    end
  end

  // ****************************************************************
  // State and output registers; clk_en low freezes everything
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;  addr_r <= 28'h0000000;  wdata_r <= 32'h00000000;
      write_r <= 1'b0;  space_r <= SP_EXT;  width_r <= BW_8;
      lw_r <= 3'h0;  wait_r <= 3'h0;  beats_r <= 2'h0;  beat_r <= 2'h0;
      need_addr_r <= 1'b0;  mux_r <= 1'b0;
      area_select_n <= CS_IDLE;  ext_addr <= 24'h000000;
      shared_addr_data_pins_out <= 16'h0000;
      shared_addr_data_pins_oe_n <= OE_OFF;
      ext_cycle <= 1'b0;  addr_phase <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;  addr_r <= addr_nxt;  wdata_r <= wdata_nxt;
      write_r <= write_nxt;  space_r <= space_nxt;  width_r <= width_nxt;
      lw_r <= lw_nxt;  wait_r <= wait_nxt;  beats_r <= beats_nxt;
      beat_r <= beat_nxt;  need_addr_r <= need_addr_nxt;  mux_r <= mux_nxt;
      area_select_n <= cs_nxt;  ext_addr <= eaddr_nxt;
      shared_addr_data_pins_out <= ad_nxt;
      shared_addr_data_pins_oe_n <= oe_nxt;
      ext_cycle <= ext_nxt;  addr_phase <= (st_nxt == ST_ADDR);
    end
  end

  assign space     = space_r;
  assign bus_width = width_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic take;  // Request accepted this edge
  assign take = clk_en && req_valid && req_ready;

  a_cs_idle_high: assert property (
    st_r == ST_IDLE |-> area_select_n == CS_IDLE)
    else $error("select low while idle");
  a_cs_area_match: assert property (
    area_select_n != CS_IDLE |->
      area_select_n == ~(8'h01 << addr_r[AREA_MSB:AREA_LSB]))
    else $error("select does not match area");
  a_cs_onchip_quiet: assert property (
    (space_r == SP_ROM || space_r == SP_PERIPH || space_r == SP_RAM ||
     space_r == SP_DRAM) |-> area_select_n == CS_IDLE)
    else $error("select low for internal or DRAM space");
  a_ext_shadow_bits: assert property (
    st_r == ST_DATA && space_r == SP_EXT |-> ext_addr[23:22] == 2'h0)
    else $error("bits 23..22 driven outside DRAM mux");
  a_rom_mode_boot: assert property (
    take && dec_area == AREA_BOOT && mode_sync_r == MODE_ROM |=>
      space == SP_ROM && bus_width == BW_32)
    else $error("mode pins did not pick on-chip ROM");
  a_rom_alias_small: assert property (
    st_r == ST_DATA && space_r == SP_ROM && !rom32_sync_r |->
      ext_addr[23:14] == 10'h000)
    else $error("ROM alias bits not ignored");
  a_lw_low_areas: assert property (
    take && dec_space == SP_EXT &&
    (dec_area == AREA_BOOT || dec_area == AREA_EXT2) |=>
      wait_r == $past(lw_low_cfg))
    else $error("areas 0/2 long wait wrong");
  a_lw_area_six: assert property (
    take && dec_space == SP_EXT && dec_area == AREA_MIO |=>
      wait_r == $past(lw_six_cfg))
    else $error("area 6 long wait wrong");
  a_long_byte_beats: assert property (
    take && req_size == SZ_LONG && dec_width == BW_8 |=> beats_r == 2'h3)
    else $error("long on 8-bit bus not four beats");
  a_mio_addr_drive: assert property (
    addr_phase && space_r == SP_MIO |->
      shared_addr_data_pins_oe_n != OE_OFF)
    else $error("muxed I/O address phase not driven");
  a_periph_alias: assert property (
    space_r == SP_PERIPH && st_r != ST_IDLE |-> ext_addr[23:9] == 15'h0)
    else $error("peripheral alias bits not ignored");

  c_long_byte: cover property (take && req_size == SZ_LONG &&
                               dec_width == BW_8 ##[1:40] xfer_done);
  c_mio_write: cover property (addr_phase && space_r == SP_MIO &&
                               write_r);
  c_dram_mux: cover property (addr_phase && space_r == SP_DRAM);
endmodule

// >>> verification/acsd_ext_mem.sv
`timescale 1ns/1ps
// ****************************************************************
// Far-side memory model
// ****************************************************************
// Counts the beats that end with an area select low. A memory on the
// far side sees only those, so the count shows whether on-chip
// traffic leaked onto the selects.
module acsd_ext_mem (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] area_select_n,
  input  wire logic       beat_end,
  output int              sel_beats
);
  // Count selected beats; reset clears the tally
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_beats <= 0;
    end else if (beat_end && area_select_n != 8'hFF) begin
      sel_beats <= sel_beats + 1;
    end
  end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import acsd_pkg::*;
  logic        ref_clk = 0, sys_rst = 1, req_valid = 0, req_write = 0;
  logic [31:0] req_addr = 0, req_wdata = 0;
  acsd_size_t  req_size = SZ_BYTE;
  logic [2:0]  mode = 0;            // Boot mode pins
  logic        rom32 = 0, dram = 0, mux = 0, mio = 0;
  logic [1:0]  lw02 = 0, lw6 = 0;   // Long wait fields
  wire         rdy, ecyc, aph, bend, done;
  acsd_space_t sp;
  acsd_width_t bw;
  wire  [7:0]  cs_n;
  wire  [23:0] eaddr;
  wire  [15:0] pins;
  wire  [1:0]  oe_n;
  int          err_count = 0, comparisons = 0, seed = 5963, ext_beats = 0;
  int          sel_beats;
  // Expected decode of the current request
  acsd_space_t e_sp;
  logic [7:0]  e_cs;
  logic [23:0] e_mask;
  int          e_wb, e_ap, e_lw, e_beats;

  always #10 ref_clk = ~ref_clk;  // 50 MHz

  acsd_decoder dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .req_valid(req_valid), .req_ready(rdy), .req_addr(req_addr),
    .req_size(req_size), .req_write(req_write), .req_wdata(req_wdata),
    .boot_mode_pins(mode), .rom_is_32k(rom32), .dram_space_enable(dram),
    .row_col_multiplex_enable(mux), .muxed_io_enable(mio),
    .low_areas_long_wait_hi(lw02[1]), .low_areas_long_wait_lo(lw02[0]),
    .area_six_long_wait_hi(lw6[1]), .area_six_long_wait_lo(lw6[0]),
    .area_select_n(cs_n), .ext_cycle(ecyc), .space(sp), .bus_width(bw),
    .ext_addr(eaddr), .shared_addr_data_pins_out(pins),
    .shared_addr_data_pins_oe_n(oe_n), .addr_phase(aph),
    .beat_end(bend), .xfer_done(done));

  acsd_ext_mem mem (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .area_select_n(cs_n), .beat_end(bend), .sel_beats(sel_beats));

  // Prints the counts and the verdict, then stops
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Behavioural decode of one address under the current config
  task automatic decode(input logic [31:0] a, input int nb);
    e_mask = EXT_MASK;
    e_sp = SP_EXT;
    e_wb = a[27] ? 2 : 1;
    case (a[26:24])
      3'h0: if (mode == MODE_ROM) begin
        e_sp = SP_ROM;
        e_wb = 4;
        e_mask = rom32 ? ROM32K_MASK : ROM16K_MASK;
      end else e_wb = (mode == MODE_EXT16) ? 2 : 1;
      3'h1: if (dram) e_sp = SP_DRAM;
      3'h5: if (!a[27]) begin
        e_sp = SP_PERIPH;
        e_mask = PERIPH_MASK;
        e_wb = a[8] ? 2 : 1;
      end
      3'h6: if (!a[27]) begin
        e_wb = a[14] ? 2 : 1;
        if (mio) e_sp = SP_MIO;
      end
      3'h7: if (a[27]) begin
        e_sp = SP_RAM;
        e_mask = RAM_MASK;
        e_wb = 4;
      end
      default: ;
    endcase
    e_cs = CS_IDLE;
    if (e_sp == SP_EXT || e_sp == SP_MIO) e_cs[a[26:24]] = 1'b0;
    e_ap = (e_sp == SP_MIO || (e_sp == SP_DRAM && mux)) ? 1 : 0;
    e_lw = 0;
    if (e_sp == SP_EXT && a[26:24] inside {3'h0, 3'h2}) e_lw = lw02 + 1;
    if (e_sp == SP_EXT && a[26:24] == 3'h6) e_lw = lw6 + 1;
    e_beats = (nb > e_wb) ? nb / e_wb : 1;
  endtask

  // One request, then every beat checked against the model
  task automatic run(input logic [31:0] a, input int sz, input logic wr,
                     input logic [31:0] wd);
    int nb, cyc, k, n;
    logic [23:0] ba;
    nb = 1 << sz;
    a = a & ~(nb - 1);  // Aligned accesses only
    decode(a, nb);
    req_valid <= 1'b1;
    req_addr <= a;
    req_size <= acsd_size_t'(sz);
    req_write <= wr;
    req_wdata <= wd;
    n = 0;
    @(negedge ref_clk);
    while (!rdy && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk(rdy, 1'b1);
    @(posedge ref_clk);  // Request taken on this edge
    req_valid <= 1'b0;
    cyc = 0;
    k = 0;
    for (n = 0; n < 60; n++) begin
      @(negedge ref_clk);
      cyc++;
      if (cyc == 1) begin
        chk(aph, e_ap[0]);
        chk(sp, e_sp);
        chk(bw, (e_wb == 4) ? BW_32 : (e_wb == 2) ? BW_16 : BW_8);
      end
      ba = a[23:0] + 24'(k * e_wb);
      // Address phases: row on the pins, or muxed I/O address
      if (aph && e_sp == SP_DRAM) chk(eaddr, {8'h00, ba[23:8]});
      if (aph && e_sp == SP_MIO) begin
        chk(pins, ba[15:0]);
        chk(oe_n, (e_wb == 2) ? 2'h0 : 2'h2);
      end
      if (bend) begin
        chk(cs_n, e_cs);
        chk(aph, 1'b0);
        chk(ecyc, e_sp inside {SP_EXT, SP_MIO, SP_DRAM});
        if (e_sp == SP_DRAM && mux) chk(eaddr, {8'h00, ba[15:0]});
        else chk(eaddr, ba & e_mask);
        if (wr && e_cs != CS_IDLE && e_wb == 1) begin
          chk(pins[7:0], wd[8*k +: 8]);
          chk(oe_n, 2'h2);
        end else if (wr && e_cs != CS_IDLE) begin
          chk(pins, (nb == 1) ? wd[15:0] : wd[16*k +: 16]);
          chk(oe_n, 2'h0);
        end else if (!wr || e_sp != SP_DRAM) begin
          // Reads and on-chip writes leave the shared pins released
          chk(oe_n, OE_OFF);
        end
        if (e_cs != CS_IDLE) ext_beats++;
        k++;
      end
      if (done) break;
    end
    if (n == 60) begin
      // Transfer never finished: count it and end the simulation
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim();
    end else begin
      chk(k, e_beats);
      chk(cyc, e_beats * (1 + e_ap + e_lw));
      @(negedge ref_clk);
      chk(cs_n, CS_IDLE);
      @(posedge ref_clk);  // Next stimulus launches on a rising edge
    end
  endtask

  initial begin
    int i, ph, r;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    chk(cs_n, CS_IDLE);
    for (ph = 0; ph < 8; ph++) begin
      @(posedge ref_clk);
      mode <= ph[2:0] % 4;  // Code 3 falls back to 8-bit external
      rom32 <= ph[2];
      repeat (3) @(posedge ref_clk);  // Let the mode pins settle
      for (i = 0; i < 40; i++) begin
        r = $random(seed);
        dram <= r[0];
        mux <= r[1];
        mio <= r[2];
        lw02 <= r[4:3];
        lw6 <= r[6:5];
        @(posedge ref_clk);
        r = $random(seed);
        // Area follows the loop; bits 31..28 stay random
        run({r[31:27], i[2:0], r[23:0]}, $unsigned($random(seed)) % 3,
            r[7], $random(seed));
      end
      $display("phase %0d done", ph);
    end
    chk(sel_beats, ext_beats);
    end_sim();
  end
endmodule
